// >>> rtl/hsr_bank_consts.svh
`ifndef HSR_BANK_CONSTS_SVH
`define HSR_BANK_CONSTS_SVH

// ==========================================
// Direct register offsets
`define HSR_OFS_WR_ADDR 8'h02
`define HSR_OFS_WR_DHI 8'h04
`define HSR_OFS_WR_DLO 8'h06
`define HSR_OFS_WR_CTL 8'h08
`define HSR_OFS_RD_ADDR 8'h0a
`define HSR_OFS_RD_CTL 8'h0c
`define HSR_OFS_RD_DHI 8'h0e
`define HSR_OFS_RD_DLO 8'h10
`define HSR_OFS_RESULT 8'h12
`define HSR_OFS_OPCFG 8'h14
`define HSR_OFS_CMD 8'h16
`define HSR_OFS_KEY 8'h1a

// ==========================================
// Indirect word addresses
`define HSR_IND_DIE 8'h00
`define HSR_IND_LOT 8'h01
`define HSR_IND_CFG_A 8'h03
`define HSR_IND_CFG_B 8'h04
`define HSR_IND_SHD_A 8'h23
`define HSR_IND_SHD_B 8'h24
`define HSR_IND_MASK 32'h03ffffff

// ==========================================
// Field positions
`define HSR_BIT_LAUNCH 15
`define HSR_BIT_BUSY 8
`define HSR_BIT_DONE 0
`define HSR_BIT_FLAG 15
`define HSR_BIT_SOFTRST 13
`define HSR_BIT_SAMPLE 12

// ==========================================
// Unlock key halves, upper first
`define HSR_KEY_HI 16'h4355
`define HSR_KEY_LO 16'h5354

// ==========================================
// Sampling scheme codes
`define HSR_SCH_SINGLE 2'h1
`define HSR_SCH_DUTY 2'h3

// ==========================================
// Timing
`define HSR_CLK_NS 10
`define HSR_OSR_SHORT 32'd40
`define HSR_OSR_LONG 32'd80
`define HSR_DC0_NS 125000
`define HSR_DC1_NS 250000
`define HSR_DC2_NS 500000
`define HSR_DC3_NS 1000000
`define HSR_DC4_NS 10000000
`define HSR_DC5_NS 100000000
`define HSR_DC6_NS 500000000
`define HSR_DC7_NS 1000000000

`endif

// >>> rtl/hsr_pkg.sv
package hsr_pkg;

   // ==========================================
   // One register request from the link side
   typedef struct packed {
      logic write;
      logic [7:0] addr;
      logic [15:0] wdata;
   } hsr_req_t;

   // Operating configuration, bits 14:1 of its register
   typedef struct packed {
      logic chkEn;
      logic [5:0] thr;
      logic [1:0] scheme;
      logic standbyCfg;
      logic [2:0] dutyPeriod;
      logic osrLong;
   } hsr_opcfg_t;

   // Conversion engine states
   typedef enum logic [1:0] {CV_IDLE, CV_WAIT, CV_RUN} hsr_conv_t;

endpackage : hsr_pkg

// >>> rtl/hsr_register_bank.sv
// Notes on behaviour
// - Writing 1 to write-control bit 15 launches indirect write; busy set, done cleared.
// - Write-control shows busy on bit 8 and done on bit 0, read-only.
// - Writing 1 to read-control bit 15 launches indirect read; busy set, done cleared.
// - Read-control shows busy on bit 8 and done on bit 0, read-only.
// - Write word is high register bytes 3,2 then low register bytes 1,0.
// - Fetched word appears as bytes 3,2 in high, 1,0 in low register.
// - Both indirect addresses are 8 bits wide; upper byte reads zero.
// - Threshold flag bit 15 of result is read-only and clears when read.
// - Result bits 14:0 hold the latest 15-bit conversion.
// - Operating bit 14 enables threshold checking, gating the flag.
// - Enabled: six result MSBs above 6-bit threshold sets flag, pulls status low.
// - Scheme 00/10 continuous, 01 single conversion, 11 duty-cycled low power.
// - Operating bit 5 selects sleep (0) or standby (1) for the sleep pin.
// - Duty-cycle field picks period 0.125 ms up to 1000 ms.
// - Operating bit 1 picks oversample length of 40 or 80 cycles.
// - Command bit 13 soft-resets the measurement path.
// - Command bit 12 starts one sample; it always reads back 0.
// - Correct key unlocks the customer-accessible indirect registers.
// - Word 0 holds die row, column, revision; word 1 lot and wafer.
// - Shadow words sit 0x20 above nonvolatile ones, loaded at power-on.
// - Factory words become readable once unlocked but stay read-only.
// - In standby only operating register and sample start accept writes.
`include "hsr_bank_consts.svh"

module hsr_register_bank
   import hsr_pkg::*;
#(
   parameter int unsigned IND_WR_CYCLES = 8,
   parameter int unsigned IND_RD_CYCLES = 2,
   parameter logic [31:0] NV_DIE_INIT = 32'h00123456, // Arbitrary
   parameter logic [31:0] NV_LOT_INIT = 32'h00234567, // Arbitrary
   parameter logic [31:0] NV_CFGA_INIT = 32'h00000000,
   parameter logic [31:0] NV_CFGB_INIT = 32'h00000000,
   parameter int unsigned DUTY_CYC [8] = '{
      `HSR_DC0_NS / `HSR_CLK_NS, `HSR_DC1_NS / `HSR_CLK_NS,
      `HSR_DC2_NS / `HSR_CLK_NS, `HSR_DC3_NS / `HSR_CLK_NS,
      `HSR_DC4_NS / `HSR_CLK_NS, `HSR_DC5_NS / `HSR_CLK_NS,
      `HSR_DC6_NS / `HSR_CLK_NS, `HSR_DC7_NS / `HSR_CLK_NS}
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic linkClk,
   input wire logic linkReq,
   input wire hsr_req_t linkReqBits,
   output logic linkAck,
   output logic [15:0] linkRdata,
   input wire logic sleepPin,
   input wire logic [14:0] adcResult,
   output logic convActive,
   output logic pathReset,
   output logic standbyActive,
   output logic statusPinOut,
   output logic statusPinOe
);

   // ==========================================
   // Link domain: request capture and answer
   logic linkRstMeta_r, linkRstn_r;
   logic linkBusy_r, reqTgl_r;
   hsr_req_t reqHold_r;
   logic ackMeta_r, ackSync_r, ackSeen_r;
   logic ackTgl_r;
   logic [15:0] rdHold_r;
   logic linkAck_r;
   logic [15:0] linkRdata_r;

   // Reset reaches the link domain through two flops
   always_ff @(posedge linkClk) begin
      linkRstMeta_r <= rstn;
      linkRstn_r <= linkRstMeta_r;
   end

   // Answer toggle from the core domain
   always_ff @(posedge linkClk) begin
      ackMeta_r <= ackTgl_r;
      ackSync_r <= ackMeta_r;
   end

   // One request in flight; a request while busy is dropped
   always_ff @(posedge linkClk) begin
      if (!linkRstn_r) begin
         linkBusy_r <= 1'b0;
         reqTgl_r <= 1'b0;
         reqHold_r <= '0;
         ackSeen_r <= 1'b0;
         linkAck_r <= 1'b0;
         linkRdata_r <= 16'h0000;
      end else begin
         linkAck_r <= 1'b0;
         if (ackSync_r != ackSeen_r) begin
            ackSeen_r <= ackSync_r;
            linkBusy_r <= 1'b0;
            linkAck_r <= 1'b1;
            linkRdata_r <= rdHold_r; // Held stable since the core edge that flipped the toggle
         end else if (linkReq && !linkBusy_r) begin
            reqHold_r <= linkReqBits;
            reqTgl_r <= ~reqTgl_r;
            linkBusy_r <= 1'b1;
         end
      end
   end

   assign linkAck = linkAck_r;
   assign linkRdata = linkRdata_r;

   // ==========================================
   // Core domain: synchronisers
   logic reqMeta_r, reqSync_r, reqSeen_r;
   logic sleepMeta_r, sleepSync_r;

   always_ff @(posedge mclk) begin
      reqMeta_r <= reqTgl_r;
      reqSync_r <= reqMeta_r;
      sleepMeta_r <= sleepPin;
      sleepSync_r <= sleepMeta_r;
   end

   // ==========================================
   // Core domain: access decode
   hsr_opcfg_t opCfg_r;
   logic accEv, accWr, accRd, wrGen, lowPower, sleepMode;
   logic [7:0] acAddr;
   logic [15:0] acData;

   assign accEv = reqSync_r ^ reqSeen_r;
   assign accWr = accEv & reqHold_r.write;
   assign accRd = accEv & ~reqHold_r.write;
   assign acAddr = reqHold_r.addr;
   assign acData = reqHold_r.wdata;
   assign lowPower = sleepSync_r;
   assign sleepMode = sleepSync_r & ~opCfg_r.standbyCfg;
   // Only operating config and sample start pass in low power
   assign wrGen = accWr & ~lowPower;

   // ==========================================
   // Unlock key
   logic keyHalf_r, unlocked_r;

   // Any other write between the halves restarts the sequence
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         keyHalf_r <= 1'b0;
         unlocked_r <= 1'b0;
      end else if (wrGen) begin
         keyHalf_r <= (acAddr == `HSR_OFS_KEY) && (acData == `HSR_KEY_HI);
         if (keyHalf_r && acAddr == `HSR_OFS_KEY && acData == `HSR_KEY_LO)
            unlocked_r <= 1'b1;
      end
   end

   // ==========================================
   // Indirect window registers
   logic [7:0] wrAddr_r, rdAddr_r;
   logic [15:0] wrDhi_r, wrDlo_r, rdDhi_r, rdDlo_r;
   logic wip_r, wdn_r, rip_r, rdn_r;
   logic [31:0] wrCnt_r, rdCnt_r;
   logic wrLaunch, rdLaunch;
   logic [31:0] fetchWord, wrWord;

   // Launch needs the key and an idle engine
   assign wrLaunch = wrGen && acAddr == `HSR_OFS_WR_CTL && acData[`HSR_BIT_LAUNCH]
                     && unlocked_r && !wip_r;
   assign rdLaunch = wrGen && acAddr == `HSR_OFS_RD_CTL && acData[`HSR_BIT_LAUNCH]
                     && unlocked_r && !rip_r;
   assign wrWord = {wrDhi_r, wrDlo_r} & `HSR_IND_MASK;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wrAddr_r <= 8'h00;
         rdAddr_r <= 8'h00;
         wrDhi_r <= 16'h0000;
         wrDlo_r <= 16'h0000;
      end else if (wrGen) begin
         case (acAddr)
            `HSR_OFS_WR_ADDR: wrAddr_r <= acData[7:0];
            `HSR_OFS_RD_ADDR: rdAddr_r <= acData[7:0];
            `HSR_OFS_WR_DHI: wrDhi_r <= acData;
            `HSR_OFS_WR_DLO: wrDlo_r <= acData;
            default: ;
         endcase
      end
   end

   // Indirect write sequencer
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wip_r <= 1'b0;
         wdn_r <= 1'b0;
         wrCnt_r <= 32'h0;
      end else if (wrLaunch) begin
         wip_r <= 1'b1;
         wdn_r <= 1'b0;
         wrCnt_r <= IND_WR_CYCLES - 1;
      end else if (wip_r) begin
         if (wrCnt_r == 32'h0) begin
            wip_r <= 1'b0;
            wdn_r <= 1'b1;
         end else begin
            wrCnt_r <= wrCnt_r - 32'h1;
         end
      end
   end

   // Indirect read sequencer; data lands as the done flag rises
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rip_r <= 1'b0;
         rdn_r <= 1'b0;
         rdCnt_r <= 32'h0;
         rdDhi_r <= 16'h0000;
         rdDlo_r <= 16'h0000;
      end else if (rdLaunch) begin
         rip_r <= 1'b1;
         rdn_r <= 1'b0;
         rdCnt_r <= IND_RD_CYCLES - 1;
      end else if (rip_r) begin
         if (rdCnt_r == 32'h0) begin
            rip_r <= 1'b0;
            rdn_r <= 1'b1;
            rdDhi_r <= fetchWord[31:16];
            rdDlo_r <= fetchWord[15:0];
         end else begin
            rdCnt_r <= rdCnt_r - 32'h1;
         end
      end
   end

   // ==========================================
   // Indirect storage
   // Power-on contents; they survive rstn, and factory words 0 and 1 are never written
   logic [31:0] nvMem [0:3] = '{NV_DIE_INIT, NV_LOT_INIT,
      NV_CFGA_INIT & `HSR_IND_MASK, NV_CFGB_INIT & `HSR_IND_MASK};
   logic [31:0] shMem [0:1];
   logic commit;

   assign commit = wip_r && wrCnt_r == 32'h0;

   always_ff @(posedge mclk) begin
      if (commit && wrAddr_r == `HSR_IND_CFG_A)
         nvMem[2] <= wrWord;
      if (commit && wrAddr_r == `HSR_IND_CFG_B)
         nvMem[3] <= wrWord;
   end

   // Shadow words reload from nonvolatile copies at reset
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         shMem[0] <= nvMem[2];
         shMem[1] <= nvMem[3];
      end else if (commit && wrAddr_r == `HSR_IND_SHD_A) begin
         shMem[0] <= wrWord;
      end else if (commit && wrAddr_r == `HSR_IND_SHD_B) begin
         shMem[1] <= wrWord;
      end
   end

   // Factory words 0 and 1 are only ever read here
   always_comb begin
      case (rdAddr_r)
         `HSR_IND_DIE: fetchWord = nvMem[0];
         `HSR_IND_LOT: fetchWord = nvMem[1];
         `HSR_IND_CFG_A: fetchWord = nvMem[2];
         `HSR_IND_CFG_B: fetchWord = nvMem[3];
         `HSR_IND_SHD_A: fetchWord = shMem[0];
         `HSR_IND_SHD_B: fetchWord = shMem[1];
         default: fetchWord = 32'h0;
      endcase
   end

   // ==========================================
   // Operating configuration and commands
   logic startCmd, softRst;

   assign startCmd = accWr && acAddr == `HSR_OFS_CMD && acData[`HSR_BIT_SAMPLE];
   assign softRst = wrGen && acAddr == `HSR_OFS_CMD && acData[`HSR_BIT_SOFTRST];

   // Writing shadow word b also refreshes the live settings
   always_ff @(posedge mclk) begin
      if (!rstn)
         opCfg_r <= hsr_opcfg_t'(nvMem[3][14:1]);
      else if (accWr && acAddr == `HSR_OFS_OPCFG)
         opCfg_r <= hsr_opcfg_t'(acData[14:1]);
      else if (commit && wrAddr_r == `HSR_IND_SHD_B)
         opCfg_r <= hsr_opcfg_t'(wrWord[14:1]);
   end

   // ==========================================
   // Conversion engine
   hsr_conv_t cvState_r;
   logic [31:0] cvCnt_r;
   logic [31:0] osrLen, dutyLen;
   logic isSingle, isDuty, cvDone;

   assign osrLen = opCfg_r.osrLong ? `HSR_OSR_LONG : `HSR_OSR_SHORT;
   assign dutyLen = DUTY_CYC[opCfg_r.dutyPeriod];
   assign isSingle = opCfg_r.scheme == `HSR_SCH_SINGLE;
   assign isDuty = opCfg_r.scheme == `HSR_SCH_DUTY;
   assign cvDone = cvState_r == CV_RUN && cvCnt_r == 32'h0;

   // Sleep and soft reset abort any conversion at once
   always_ff @(posedge mclk) begin
      if (!rstn || softRst || sleepMode) begin
         cvState_r <= CV_IDLE;
         cvCnt_r <= 32'h0;
      end else begin
         case (cvState_r)
            CV_IDLE: begin
               if (startCmd || (!isSingle && !isDuty)) begin
                  cvState_r <= CV_RUN;
                  cvCnt_r <= osrLen - 32'h1;
               end else if (isDuty) begin
                  cvState_r <= CV_WAIT;
                  cvCnt_r <= dutyLen - 32'h1;
               end
            end
            CV_WAIT: begin
               if (startCmd || cvCnt_r == 32'h0) begin
                  cvState_r <= CV_RUN;
                  cvCnt_r <= osrLen - 32'h1;
               end else begin
                  cvCnt_r <= cvCnt_r - 32'h1;
               end
            end
            CV_RUN: begin
               if (cvCnt_r == 32'h0)
                  cvState_r <= CV_IDLE;
               else
                  cvCnt_r <= cvCnt_r - 32'h1;
            end
            default: cvState_r <= CV_IDLE;
         endcase
      end
   end

   // ==========================================
   // Result and threshold flag
   logic [14:0] result_r;
   logic flag_r, flagSet, flagClr, flagNxt;

   assign flagSet = cvDone && opCfg_r.chkEn && (adcResult[14:9] > opCfg_r.thr);
   assign flagClr = accRd && acAddr == `HSR_OFS_RESULT;
   // A new crossing in the same cycle as the clearing read wins
   assign flagNxt = flagSet | (flag_r & ~flagClr);

   // Whole word lands in one edge
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         result_r <= 15'h0000;
         flag_r <= 1'b0;
      end else begin
         if (cvDone)
            result_r <= adcResult;
         flag_r <= flagNxt;
      end
   end

   // ==========================================
   // Read multiplexer and answer
   logic [15:0] rdData;

   // Low power leaves only the result register readable
   always_comb begin
      rdData = 16'h0000;
      if (!lowPower || acAddr == `HSR_OFS_RESULT) begin
         case (acAddr)
            `HSR_OFS_WR_ADDR: rdData = {8'h00, wrAddr_r};
            `HSR_OFS_WR_DHI: rdData = wrDhi_r;
            `HSR_OFS_WR_DLO: rdData = wrDlo_r;
            `HSR_OFS_WR_CTL: rdData = {7'h00, wip_r, 7'h00, wdn_r};
            `HSR_OFS_RD_ADDR: rdData = {8'h00, rdAddr_r};
            `HSR_OFS_RD_CTL: rdData = {7'h00, rip_r, 7'h00, rdn_r};
            `HSR_OFS_RD_DHI: rdData = rdDhi_r;
            `HSR_OFS_RD_DLO: rdData = rdDlo_r;
            `HSR_OFS_RESULT: rdData = {flag_r, result_r};
            `HSR_OFS_OPCFG: rdData = {1'b0, opCfg_r, 1'b0};
            `HSR_OFS_KEY: rdData = {15'h0000, unlocked_r};
            default: rdData = 16'h0000;
         endcase
      end
   end

   // Hold answer in the same edge as the toggle; the link side reads it settled
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         reqSeen_r <= 1'b0;
         ackTgl_r <= 1'b0;
         rdHold_r <= 16'h0000;
      end else if (accEv) begin
         reqSeen_r <= reqSync_r;
         ackTgl_r <= ~ackTgl_r;
         rdHold_r <= rdData;
      end
   end

   // ==========================================
   // Pins and status outputs
   logic convActive_r, pathReset_r, standby_r, statusOut_r, statusOe_r;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         convActive_r <= 1'b0;
         pathReset_r <= 1'b0;
         standby_r <= 1'b0;
         statusOut_r <= 1'b0;
         statusOe_r <= 1'b0;
      end else begin
         convActive_r <= cvState_r == CV_RUN;
         pathReset_r <= softRst;
         standby_r <= sleepSync_r & opCfg_r.standbyCfg;
         statusOut_r <= 1'b0;
         statusOe_r <= flagNxt;
      end
   end

   assign convActive = convActive_r;
   assign pathReset = pathReset_r;
   assign standbyActive = standby_r;
   assign statusPinOut = statusOut_r;
   assign statusPinOe = statusOe_r;

endmodule : hsr_register_bank

// >>> test/hall_sensor_register_bank_tb_top.sv
module hall_sensor_register_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import hsr_pkg::*;

   localparam logic [31:0] DIE_W = 32'h0029a5c3; // Arbitrary
   localparam logic [31:0] CFGB_W = 32'h00006020;
   logic mclk = 1'b0, rstn = 1'b0, linkClk = 1'b0, sleepPin = 1'b0, seenPr = 1'b0;
   logic convQ = 1'b0;
   logic [14:0] adcResult = 15'h7fff;
   logic linkReq, linkAck, convActive, pathReset, standbyActive, statusPinOut, statusPinOe;
   logic [15:0] linkRdata, rv;
   hsr_req_t linkReqBits;
   int numErrors = 0, numChecks = 0, cyc = 0, rises = 0, n, g, r0;
   logic [15:0] cfgTab [5] = '{16'h0020, 16'h0022, 16'h00a0, 16'h00e0, 16'h00ec};
   int lenTab [5] = '{40, 80, 40, 40, 40};
   int gapTab [5] = '{1, 1, 1, 10, 40};

   always #5 mclk = ~mclk;
   // Link clock starts off the core grid so no link edge meets a core edge
   initial begin
      #3;
      forever #80 linkClk = ~linkClk;
   end

   hsr_register_bank #(.NV_DIE_INIT(DIE_W), .NV_CFGB_INIT(CFGB_W),
      .DUTY_CYC('{10, 20, 30, 40, 50, 60, 70, 80})) u_dut (.mclk(mclk), .rstn(rstn),
      .linkClk(linkClk), .linkReq(linkReq), .linkReqBits(linkReqBits), .linkAck(linkAck),
      .linkRdata(linkRdata), .sleepPin(sleepPin), .adcResult(adcResult),
      .convActive(convActive), .pathReset(pathReset), .standbyActive(standbyActive),
      .statusPinOut(statusPinOut), .statusPinOe(statusPinOe));
   hsr_host_model u_host (.linkClk(linkClk), .linkAck(linkAck), .linkRdata(linkRdata),
      .linkReqBits(linkReqBits), .linkReq(linkReq));

   // ==========================================
   // Watchers: conversion starts, soft reset pulse, hang limit
   always @(posedge mclk) begin
      convQ <= convActive;
      if (convActive === 1'b1 && convQ === 1'b0) rises++;
      if (pathReset === 1'b1) seenPr <= 1'b1;
      cyc++;
      if (cyc == 60000) begin
         numErrors++;
         wrapUp();
      end
   end

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      numChecks++;
      if (seen !== exp) begin
         numErrors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
      logic ok;
      u_host.xfer(wr, a, d, rv, ok);
      chk({15'h0, ok}, 16'h0001);
   endtask : acc
   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      acc(1'b0, a, 16'h0000);
      chk(rv, exp);
   endtask : rdc
   task automatic ind_rd(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b1, 8'h0a, {8'h00, a});
      acc(1'b1, 8'h0c, 16'h8000);
      rdc(8'h0c, 16'h0001);
      rdc(8'h0e, exp[31:16]);
      rdc(8'h10, exp[15:0]);
   endtask : ind_rd
   task automatic ind_wr(input logic [7:0] a, input logic [31:0] w);
      acc(1'b1, 8'h02, {8'h00, a});
      acc(1'b1, 8'h04, w[31:16]);
      acc(1'b1, 8'h06, w[15:0]);
      acc(1'b1, 8'h08, 16'h8000);
      rdc(8'h08, 16'h0001);
   endtask : ind_wr
   task automatic wait_lvl(input logic v, input int lim, output int cnt);
      cnt = 0;
      while (convActive !== v && cnt < lim) begin
         @(negedge mclk);
         cnt++;
      end
   endtask : wait_lvl
   task automatic wrapUp;
      $display("checks %0d errors %0d", numChecks, numErrors);
      if (numErrors == 0 && numChecks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrapUp

   // ==========================================
   // Main sequence
   initial begin
      repeat (16) @(negedge linkClk);
      @(negedge mclk) rstn = 1'b1;
      repeat (4) @(negedge linkClk);
      // Locked: key reads 0, unmapped reads 0, launch is ignored
      rdc(8'h1a, 16'h0000);
      rdc(8'h18, 16'h0000);
      acc(1'b1, 8'h0c, 16'h8000);
      rdc(8'h0c, 16'h0000);
      acc(1'b1, 8'h1a, 16'h4355);
      acc(1'b1, 8'h1a, 16'h5354);
      rdc(8'h1a, 16'h0001);
      rdc(8'h14, CFGB_W[15:0]);
      ind_rd(8'h24, CFGB_W);
      ind_wr(8'h24, CFGB_W);
      ind_wr(8'h00, 32'h0);
      ind_rd(8'h00, DIE_W);
      ind_wr(8'h23, 32'h01234567);
      rdc(8'h02, 16'h0023);
      ind_rd(8'h23, 32'h01234567);
      // Threshold flag: boundary value does not raise it, one above does
      wait_lvl(1'b1, 200, n);
      wait_lvl(1'b0, 200, n);
      chk({15'h0, statusPinOe}, 16'h0001);
      @(negedge mclk) adcResult = 15'h41ff;
      repeat (2) begin
         wait_lvl(1'b1, 200, n);
         wait_lvl(1'b0, 200, n);
      end
      rdc(8'h12, 16'hc1ff);
      rdc(8'h12, 16'h41ff);
      chk({15'h0, statusPinOe}, 16'h0000);
      chk({15'h0, statusPinOut}, 16'h0000);
      @(negedge mclk) adcResult = 15'h4200;
      repeat (2) wait_lvl(1'b0, 200, n);
      wait_lvl(1'b1, 200, n);
      wait_lvl(1'b0, 200, n);
      rdc(8'h12, 16'hc200);
      acc(1'b1, 8'h14, 16'h2020);
      rdc(8'h12, 16'hc200);
      repeat (2) begin
         wait_lvl(1'b1, 200, n);
         wait_lvl(1'b0, 200, n);
      end
      rdc(8'h12, 16'h4200);
      // Soft reset during a run
      wait_lvl(1'b1, 200, n);
      acc(1'b1, 8'h16, 16'h2000);
      chk({15'h0, seenPr}, 16'h0001);
      // Run length and idle gap for continuous and duty-cycled schemes, both lengths, periods 0 and 3
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, 8'h14, cfgTab[i]);
         wait_lvl(1'b0, 200, n);
         wait_lvl(1'b1, 200, n);
         wait_lvl(1'b0, 200, n);
         chk(n[15:0], lenTab[i][15:0]);
         wait_lvl(1'b1, 200, g);
         chk({15'h0, g >= gapTab[i] && g <= gapTab[i] + 2}, 16'h0001);
      end
      // Single conversion only on command
      acc(1'b1, 8'h14, 16'h0060);
      wait_lvl(1'b0, 200, n);
      r0 = rises;
      repeat (300) @(negedge mclk);
      chk(rises[15:0], r0[15:0]);
      acc(1'b1, 8'h16, 16'h1000);
      repeat (100) @(negedge mclk);
      chk(rises[15:0], r0[15:0] + 16'h0001);
      rdc(8'h16, 16'h0000);
      // Standby: only operating register writes, result still readable
      @(negedge mclk) sleepPin = 1'b1;
      repeat (10) @(negedge mclk);
      chk({15'h0, standbyActive}, 16'h0001);
      acc(1'b1, 8'h02, 16'h0055);
      rdc(8'h02, 16'h0000);
      rdc(8'h12, 16'h4200);
      acc(1'b1, 8'h14, 16'h2022);
      @(negedge mclk) sleepPin = 1'b0;
      repeat (10) @(negedge mclk);
      rdc(8'h02, 16'h0023);
      rdc(8'h14, 16'h2022);
      wrapUp();
   end
endmodule : hall_sensor_register_bank_tb_top

// >>> test/hsr_bank_props.sv
module hsr_bank_props
   import hsr_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic linkClk,
   input wire logic linkReq,
   input wire hsr_req_t linkReqBits,
   input wire logic linkAck,
   input wire logic [15:0] linkRdata,
   input wire logic sleepPin,
   input wire logic [14:0] adcResult,
   input wire logic convActive,
   input wire logic pathReset,
   input wire logic standbyActive,
   input wire logic statusPinOut,
   input wire logic statusPinOe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   // ==========================================
   // Length of the running conversion window
   int runLen_r;
   always_ff @(posedge mclk) begin
      if (!rstn || !convActive) runLen_r <= 0;
      else runLen_r <= runLen_r + 1;
   end

   // ==========================================
   // Core domain
   a_pin_never_high: assert property (statusPinOut == 1'b0)
      else $error("status pin driven high");
   a_pin_after_conv: assert property ($rose(statusPinOe) |-> $past(convActive))
      else $error("status pin pulled outside a conversion end");
   // A soft reset cuts the run short; its pulse stands one cycle before the fall
   a_run_length: assert property ($fell(convActive) |->
      (runLen_r == 40 || runLen_r == 80 || $past(pathReset)))
      else $error("conversion window length wrong");
   a_prst_one_pulse: assert property (pathReset |=> !pathReset)
      else $error("path reset longer than one cycle");
   a_abort_stops_run: assert property (pathReset |-> ##[0:1] !convActive)
      else $error("conversion kept running through soft reset");
   a_standby_needs_pin: assert property ((!sleepPin) [*4] |-> !standbyActive)
      else $error("standby without pin");

   // ==========================================
   // Link domain
   a_ack_one_cycle: assert property (@(posedge linkClk) disable iff (!rstn)
      linkAck |=> !linkAck)
      else $error("answer strobe too long");
   a_ack_answers_req: assert property (@(posedge linkClk) disable iff (!rstn)
      linkReq && !linkAck |-> ##[2:10] linkAck)
      else $error("request not answered");
   a_rdata_holds: assert property (@(posedge linkClk) disable iff (!rstn)
      !linkAck |-> $stable(linkRdata))
      else $error("read data changed without answer");

   c_flag_raised: cover property ($rose(statusPinOe));
   c_soft_reset: cover property (pathReset);
   c_standby: cover property ($rose(standbyActive));
   c_long_run: cover property ($fell(convActive) && runLen_r == 80);
endmodule : hsr_bank_props

bind hsr_register_bank hsr_bank_props u_props (.mclk(mclk), .rstn(rstn), .linkClk(linkClk),
   .linkReq(linkReq), .linkReqBits(linkReqBits), .linkAck(linkAck), .linkRdata(linkRdata),
   .sleepPin(sleepPin), .adcResult(adcResult), .convActive(convActive),
   .pathReset(pathReset), .standbyActive(standbyActive), .statusPinOut(statusPinOut),
   .statusPinOe(statusPinOe));

// >>> test/hsr_host_model.sv
module hsr_host_model
   import hsr_pkg::*;
(
   input wire logic linkClk,
   input wire logic linkAck,
   input wire logic [15:0] linkRdata,
   output hsr_req_t linkReqBits,
   output logic linkReq
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      linkReq = 1'b0;
      linkReqBits = '0;
   end

   // ==========================================
   // One transfer: strobe for one cycle, then wait a bounded time for the answer
   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [15:0] wd,
                       output logic [15:0] rd, output logic ok);
      int n;
      @(negedge linkClk);
      linkReqBits = '{write: wr, addr: adr, wdata: wd};
      linkReq = 1'b1;
      @(negedge linkClk);
      linkReq = 1'b0;
      linkReqBits = ~linkReqBits; // Released lines must not look valid
      ok = 1'b0;
      rd = '0;
      for (n = 0; n < 12 && !ok; n++) begin
         @(posedge linkClk);
         if (linkAck === 1'b1) begin
            ok = 1'b1;
            rd = linkRdata;
         end
      end
   endtask : xfer
endmodule : hsr_host_model
